// ===== rtl/ctp_regs.sv
// Thermal profile control and charger status register bank
//
// Functional notes
// - Mirror bit copies warm offsets into cool zones
// - Pre-warm voltage offset: -300/-200/-100/none
// - Pre-warm current: suspend/20%/40%/unchanged
// - Pre-cool current uses the same encoding
// - Control register resets to 3Fh, bit7 zero
// - ADC done only in one-shot, else zero
// - Bit 5 shows die thermal regulation
// - Bit 4 shows minimum system regulation
// - Bit 3 shows input or pin current loop
// - Bit 2 shows input voltage regulation
// - Bit 1 shows charge safety timer expiry
// - Bit 0 shows watchdog timer expiry
// - Bits 4:3 report the charge phase
// - Bits 2:0 report the input source
// - Status registers read-only, reset zero
// - Warm offset uses same voltage encoding
// - Phase change raises the change flag
`include "ctp_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module ctp_regs (
	input  wire logic                sys_clk_i,                 // 200 MHz system clock
	input  wire logic                srst_i,                    // Synchronous reset, high
	input  wire logic                reg_reset_i,               // Register reset event pulse
	input  wire logic                wr_en_i,                   // Serial-bus write strobe
	input  wire logic                rd_en_i,                   // Serial-bus read strobe
	input  wire logic [7:0]          addr_i,                    // Register address
	input  wire logic [7:0]          wdata_i,                   // Write data
	input  wire logic [1:0]          warm_voltage_offset_i,     // Warm offset from neighbour register
	input  wire ctp_pkg::ctp_zone_t  zone_i,                    // Present temperature zone
	input  wire logic                adc_one_shot_i,            // ADC in one-shot mode
	input  wire logic                adc_conv_done_i,           // One-shot conversion finished
	input  wire logic                thermal_reg_active_i,      // Die thermal loop active
	input  wire logic                forward_mode_i,            // Device in forward mode
	input  wire logic                min_sys_reg_active_i,      // Battery below minimum system
	input  wire logic                input_current_reg_i,       // Input current loop active
	input  wire logic                current_limit_pin_reg_i,   // Limit-pin loop active
	input  wire logic                input_voltage_reg_i,       // Input voltage loop active
	input  wire logic                charge_timer_expired_i,    // Safety timer expired
	input  wire logic                watchdog_expired_i,        // Watchdog timer expired
	input  wire ctp_pkg::ctp_phase_t charge_phase_i,            // Live charge phase
	input  wire logic [2:0]          input_source_i,            // Live input source code
	output logic      [7:0]          rdata_o,                   // Read data
	output logic                     rvalid_o,                  // Read data valid pulse
	output logic      [1:0]          charge_voltage_offset_o,   // Active regulation offset code
	output logic      [1:0]          charge_current_scale_o,    // Active current scale code
	output logic                     charge_phase_change_flag_o // Phase change pulse
);
	import ctp_pkg::*;

	logic [7:0] profile_ctrl;      // Control register storage
	logic [7:0] status_zero;       // Live status snapshot
	logic [7:0] status_one;        // Live phase and source snapshot
	logic [1:0] phase_prev;        // Last sampled phase
	logic [1:0] next_voltage;      // Offset for present zone
	logic [1:0] next_current;      // Scale for present zone
	logic [7:0] next_rdata;        // Read mux result

	// Mirror bit and field extraction
	wire logic       mirror     = profile_ctrl[`CTP_MIRROR_BIT];
	wire logic [1:0] pw_volt    = profile_ctrl[`CTP_PW_VOLT_HI:`CTP_PW_VOLT_LO];
	wire logic [1:0] pw_curr    = profile_ctrl[`CTP_PW_CURR_HI:`CTP_PW_CURR_LO];
	wire logic [1:0] pc_curr    = profile_ctrl[`CTP_PC_CURR_HI:`CTP_PC_CURR_LO];

	// Control register; register reset restores defaults, bit 7 stays zero
	always_ff @(posedge sys_clk_i) begin
		if (srst_i || reg_reset_i) begin
			profile_ctrl <= `CTP_PROFILE_RESET;
		end else if (wr_en_i && addr_i == `CTP_ADDR_PROFILE_CTRL) begin
			profile_ctrl <= wdata_i & `CTP_PROFILE_WMASK;
		end
	end

	// Status zero mirrors live conditions; writes never touch it
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			status_zero <= `CTP_STATUS_RESET;
		end else begin
			status_zero[7] <= 1'b0;
			// Continuous mode forces zero
			status_zero[6] <= adc_one_shot_i & adc_conv_done_i;
			status_zero[5] <= thermal_reg_active_i;
			status_zero[4] <= forward_mode_i & min_sys_reg_active_i;
			status_zero[3] <= forward_mode_i &
				(input_current_reg_i | current_limit_pin_reg_i);
			status_zero[2] <= forward_mode_i & input_voltage_reg_i;
			status_zero[1] <= charge_timer_expired_i;
			status_zero[0] <= watchdog_expired_i;
		end
	end

	// Status one: phase and source, upper bits zero
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			status_one <= `CTP_STATUS_RESET;
		end else begin
			status_one <= {3'h0, charge_phase_i, input_source_i};
		end
	end

	// Phase change detection against the previous sample
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			phase_prev                 <= 2'h0;
			charge_phase_change_flag_o <= 1'b0;
		end else begin
			phase_prev                 <= charge_phase_i;
			charge_phase_change_flag_o <= (phase_prev != charge_phase_i);
		end
	end

	// Zone-dependent regulation selection
	always_comb begin
		next_voltage = `CTP_OFS_NONE;
		next_current = `CTP_CUR_FULL;
		unique case (zone_i)
			CTP_ZONE_PREWARM: begin
				next_voltage = pw_volt;
				next_current = pw_curr;
			end
			CTP_ZONE_PRECOOL: begin
				next_voltage = mirror ? pw_volt : `CTP_OFS_NONE;
				next_current = pc_curr;
			end
			CTP_ZONE_COOL: begin
				// Cool current belongs to another register; only voltage here
				next_voltage = mirror ? warm_voltage_offset_i : `CTP_OFS_NONE;
			end
			CTP_ZONE_WARM: begin
				next_voltage = warm_voltage_offset_i;
			end
			CTP_ZONE_COLD, CTP_ZONE_HOT, CTP_ZONE_FAULT: begin
				// Charging stops in these zones
				next_current = `CTP_CUR_SUSPEND;
			end
			CTP_ZONE_NORMAL: begin
				// Normal zone keeps full regulation
				next_voltage = `CTP_OFS_NONE;
			end
		endcase
	end

	// Registered regulation outputs
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			charge_voltage_offset_o <= `CTP_OFS_NONE;
			charge_current_scale_o  <= `CTP_CUR_FULL;
		end else begin
			charge_voltage_offset_o <= next_voltage;
			charge_current_scale_o  <= next_current;
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		unique case (addr_i)
			`CTP_ADDR_PROFILE_CTRL: next_rdata = profile_ctrl;
			`CTP_ADDR_STATUS_ZERO:  next_rdata = status_zero;
			`CTP_ADDR_STATUS_ONE:   next_rdata = status_one;
			default:                next_rdata = 8'h00;
		endcase
	end

	// Read data registered one cycle after the strobe, held until the next read
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			rdata_o  <= 8'h00;
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= rd_en_i;
			if (rd_en_i) begin
				rdata_o <= next_rdata;
			end
		end
	end

endmodule : ctp_regs

`default_nettype wire

// ===== rtl/ctp_defs.svh
// Register offsets, field positions, reset values and encodings for the thermal profile bank
`ifndef CTP_DEFS_SVH
`define CTP_DEFS_SVH

`define CTP_ADDR_PROFILE_CTRL   8'h1C
`define CTP_ADDR_STATUS_ZERO    8'h1D
`define CTP_ADDR_STATUS_ONE     8'h1E

`define CTP_PROFILE_RESET       8'h3F
`define CTP_STATUS_RESET        8'h00
`define CTP_PROFILE_WMASK       8'h7F

`define CTP_MIRROR_BIT          6
`define CTP_PW_VOLT_HI          5
`define CTP_PW_VOLT_LO          4
`define CTP_PW_CURR_HI          3
`define CTP_PW_CURR_LO          2
`define CTP_PC_CURR_HI          1
`define CTP_PC_CURR_LO          0

`define CTP_OFS_MINUS_300       2'h0
`define CTP_OFS_MINUS_200       2'h1
`define CTP_OFS_MINUS_100       2'h2
`define CTP_OFS_NONE            2'h3

`define CTP_CUR_SUSPEND         2'h0
`define CTP_CUR_PCT20           2'h1
`define CTP_CUR_PCT40           2'h2
`define CTP_CUR_FULL            2'h3

`define CTP_SRC_NONE            3'h0
`define CTP_SRC_UNKNOWN         3'h4

`endif

// ===== rtl/ctp_pkg.sv
// Types shared by the thermal profile and status register bank
package ctp_pkg;

	// Temperature zone as reported by the thermistor comparators
	typedef enum logic [2:0] {
		CTP_ZONE_NORMAL,
		CTP_ZONE_COLD,
		CTP_ZONE_HOT,
		CTP_ZONE_COOL,
		CTP_ZONE_WARM,
		CTP_ZONE_PRECOOL,
		CTP_ZONE_PREWARM,
		CTP_ZONE_FAULT
	} ctp_zone_t;

	// Charge phase field encoding
	typedef enum logic [1:0] {
		CTP_PHASE_IDLE,
		CTP_PHASE_CC,
		CTP_PHASE_CV,
		CTP_PHASE_TOPOFF
	} ctp_phase_t;

endpackage : ctp_pkg

// ===== verification/ctp_regs_asserts.sv
// Port-level checks for the thermal profile register bank
`timescale 1ns/1ps
`default_nettype none
module ctp_regs_asserts (
	input wire logic sys_clk_i, srst_i, reg_reset_i, rd_en_i, adc_one_shot_i, adc_conv_done_i,
	input wire logic thermal_reg_active_i, forward_mode_i, input_current_reg_i, watchdog_expired_i,
	input wire logic current_limit_pin_reg_i, charge_phase_change_flag_o,
	input wire logic min_sys_reg_active_i, input_voltage_reg_i, charge_timer_expired_i,
	input wire logic [7:0] addr_i, rdata_o,
	input wire logic [2:0] input_source_i,
	input wire ctp_pkg::ctp_phase_t charge_phase_i
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	// Status reads with inputs held, so latch timing cannot matter
	sequence s_rd0;
		rd_en_i && addr_i == 8'h1D && !$past(srst_i) && $stable({adc_one_shot_i, adc_conv_done_i,
			thermal_reg_active_i, forward_mode_i, input_current_reg_i, current_limit_pin_reg_i,
			watchdog_expired_i, min_sys_reg_active_i, input_voltage_reg_i, charge_timer_expired_i});
	endsequence
	sequence s_rd1;
		rd_en_i && addr_i == 8'h1E && !$past(srst_i) && $stable({charge_phase_i, input_source_i});
	endsequence
	property p_adc; s_rd0 |=> rdata_o[6] == $past(adc_one_shot_i && adc_conv_done_i); endproperty
	property p_treg; s_rd0 |=> rdata_o[5] == $past(thermal_reg_active_i); endproperty
	property p_iin;
		s_rd0 |=> rdata_o[3] == $past(forward_mode_i && (input_current_reg_i || current_limit_pin_reg_i));
	endproperty
	property p_wd; s_rd0 |=> rdata_o[0] == $past(watchdog_expired_i) && !rdata_o[7]; endproperty
	property p_fwd;
		s_rd0 |=> rdata_o[4] == $past(forward_mode_i && min_sys_reg_active_i)
			&& rdata_o[2] == $past(forward_mode_i && input_voltage_reg_i)
			&& rdata_o[1] == $past(charge_timer_expired_i);
	endproperty
	property p_phase; s_rd1 |=> rdata_o[4:3] == $past(charge_phase_i); endproperty
	property p_src; s_rd1 |=> rdata_o[7:5] == 3'h0 && rdata_o[2:0] == $past(input_source_i); endproperty
	property p_ctl; reg_reset_i ##1 (rd_en_i && addr_i == 8'h1C) |=> rdata_o == 8'h3F; endproperty
	property p_flag;
		!$past(srst_i) && $changed(charge_phase_i) |-> ##[1:2] charge_phase_change_flag_o;
	endproperty
	a_adc: assert property (p_adc) else $error("adc done bit wrong");
	a_treg: assert property (p_treg) else $error("thermal bit wrong");
	a_iin: assert property (p_iin) else $error("input current bit wrong");
	a_wd: assert property (p_wd) else $error("watchdog bit wrong");
	a_fwd: assert property (p_fwd) else $error("system, voltage or timer bit wrong");
	a_phase: assert property (p_phase) else $error("phase field wrong");
	a_src: assert property (p_src) else $error("source field wrong");
	a_ctl: assert property (p_ctl) else $error("control not restored");
	a_flag: assert property (p_flag) else $error("phase change not flagged");
endmodule : ctp_regs_asserts
`default_nettype wire

// ===== verification/ctp_host.sv
// Host processor model issuing single-byte register accesses
`timescale 1ns/1ps
`default_nettype none
module ctp_host (
	input  wire logic       sys_clk_i,
	output logic            wr_en_o,
	output logic            rd_en_o,
	output logic [7:0]      addr_o,
	output logic [7:0]      wdata_o
);
	logic [7:0] exp_q[$];	// Expected read bytes, oldest first
	initial {wr_en_o, rd_en_o, addr_o, wdata_o} = 18'h0_0000;
	// One-cycle strobe; idle bus shows inverted values so stale data cannot pass
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i) #1;
		{wr_en_o, rd_en_o, addr_o, wdata_o} = {w, !w, a, d};
		@(posedge sys_clk_i) #1;
		{wr_en_o, rd_en_o, addr_o, wdata_o} = {2'b00, ~a, ~d};
	endtask : xfer
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		xfer(1'b0, a, 8'h00);
	endtask : rd
endmodule : ctp_host
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the thermal profile register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ctp_pkg::*;
	logic        sys_clk_i = 1'b0, srst_i = 1'b1, reg_reset_i = 1'b0, wr_en_i, rd_en_i, rvalid_o;
	logic [7:0]  addr_i, wdata_i, rdata_o, ctl;
	logic [9:0]  st = 10'h000;	// Packed status condition inputs
	logic [1:0]  warm = 2'h1, vo, cs;
	logic [2:0]  src = 3'h0;
	logic [1:0]  oph;	// Phase before the latest change
	logic        flg;	// Phase change pulse seen
	logic [15:0] rs = 16'h47E4;	// Xorshift state
	ctp_phase_t  ph = CTP_PHASE_IDLE;
	ctp_zone_t   zone = CTP_ZONE_NORMAL;
	ctp_zone_t   zl[8] = '{CTP_ZONE_NORMAL, CTP_ZONE_COOL, CTP_ZONE_WARM, CTP_ZONE_PRECOOL,
		CTP_ZONE_PREWARM, CTP_ZONE_COLD, CTP_ZONE_HOT, CTP_ZONE_FAULT};
	int          error_cnt = 0, num_checks = 0;
	always #2.5 sys_clk_i = ~sys_clk_i;
	ctp_host host (.sys_clk_i, .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i), .wdata_o(wdata_i));
	ctp_regs dut (.sys_clk_i, .srst_i, .reg_reset_i, .wr_en_i, .rd_en_i, .addr_i, .wdata_i,
		.warm_voltage_offset_i(warm), .zone_i(zone), .adc_one_shot_i(st[0]), .adc_conv_done_i(st[1]),
		.thermal_reg_active_i(st[2]), .forward_mode_i(st[3]), .min_sys_reg_active_i(st[4]),
		.input_current_reg_i(st[5]), .current_limit_pin_reg_i(st[6]), .input_voltage_reg_i(st[7]),
		.charge_timer_expired_i(st[8]), .watchdog_expired_i(st[9]), .charge_phase_i(ph),
		.input_source_i(src), .rdata_o, .rvalid_o, .charge_voltage_offset_o(vo),
		.charge_current_scale_o(cs), .charge_phase_change_flag_o(flg));
	function automatic logic [15:0] xs(input logic [15:0] v);
		v ^= v << 7;
		v ^= v >> 9;
		return v ^ (v << 8);
	endfunction : xs
	// Offset and scale codes expected in each zone
	function automatic logic [3:0] ez(input ctp_zone_t z);
		case (z)
			CTP_ZONE_PREWARM: return ctl[5:2];
			CTP_ZONE_PRECOOL: return {ctl[6] ? ctl[5:4] : 2'h3, ctl[1:0]};
			CTP_ZONE_COOL: return {ctl[6] ? warm : 2'h3, 2'h3};
			CTP_ZONE_WARM: return {warm, 2'h3};
			CTP_ZONE_COLD, CTP_ZONE_HOT, CTP_ZONE_FAULT: return 4'hC;
			default: return 4'hF;
		endcase
	endfunction : ez
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out
	// Read results matched against the oldest noted expectation
	always @(negedge sys_clk_i) if (rvalid_o === 1'b1) chk("rdata", host.exp_q.pop_front(), rdata_o);
	initial begin
		#60000;
		error_cnt++;
		close_out();
	end
	initial begin
		repeat (12) @(posedge sys_clk_i);
		#1 srst_i = 1'b0;
		host.rd(8'h1C, 8'h3F);
		host.rd(8'h1D, 8'h00);
		host.rd(8'h55, 8'h00);
		for (int i = 0; i < 24; i++) begin
			rs = xs(rs);
			{warm, src, st} = rs[14:0];
			oph = ph;
			ph = ctp_phase_t'(rs[14:13]);
			ctl = rs[15:8] & 8'h7F;
			@(posedge sys_clk_i) #1 chk("flag", {7'h00, ph != oph}, {7'h00, flg});
			host.xfer(1'b1, 8'h1C, rs[15:8]);
			host.rd(8'h1C, ctl);
			host.xfer(1'b1, 8'h1D, rs[7:0]);
			host.rd(8'h1D, {1'b0, st[0] & st[1], st[2], st[3] & st[4], st[3] & (st[5] | st[6]),
				st[3] & st[7], st[8], st[9]});
			host.xfer(1'b1, 8'h1E, rs[7:0]);
			host.rd(8'h1E, {3'h0, ph, src});
			foreach (zl[j]) begin
				@(posedge sys_clk_i) #1 zone = zl[j];
				repeat (2) @(posedge sys_clk_i);
				#1 chk("zone", {4'h0, ez(zl[j])}, {4'h0, vo, cs});
			end
		end
		$display("status and profile test done");
		@(posedge sys_clk_i) #1 reg_reset_i = 1'b1;
		fork
			host.rd(8'h1C, 8'h3F);
			@(posedge sys_clk_i) #1 reg_reset_i = 1'b0;
		join
		repeat (4) @(posedge sys_clk_i);
		$display("register reset test done");
		close_out();
	end
endmodule : testbench
bind ctp_regs ctp_regs_asserts chk (.*);
`default_nettype wire
